// file: testbench/amp_mem_model.sv
// External asynchronous memory with programmable wait states
`timescale 1ns/1ps
`include "amp_params.svh"
module amp_mem_model (
    input  wire logic                   core_clk,
    input  wire logic [`AMP_ADDR_W-1:0] addr,
    input  wire logic [1:0]             sel_n,
    input  wire logic                   rd_n,
    input  wire logic                   wr_n,
    input  wire logic [`AMP_DATA_W-1:0] dout,
    input  wire logic [`AMP_DATA_W-1:0] doe,
    input  wire logic [7:0]             wait_cyc,
    output logic      [`AMP_DATA_W-1:0] din,
    output logic                        ack
);
    logic [`AMP_DATA_W-1:0] mem [256];
    logic [7:0]             cnt = 8'h00;
    logic                   hit;
    assign hit = (sel_n != 2'h3);
    always @(posedge core_clk) begin
        cnt <= (rd_n && wr_n) ? 8'h00 : cnt + 8'h01;
        if (!wr_n && hit) begin
            mem[addr[7:0]] <= dout;
        end
    end
    // Wait states while strobe low, pull-up when idle
    assign ack = (rd_n && wr_n) || (cnt >= wait_cyc);
    // Released bus floats to the pull-up level
    assign din = (dout & doe) | (~doe & ((!rd_n && hit) ? mem[addr[7:0]] : 16'hFFFF));
endmodule

// file: testbench/amp_top_chk.sv
// Pin-level checks for the asynchronous memory port
`timescale 1ns/1ps
`include "amp_params.svh"
module amp_top_chk (
    input wire logic                   core_clk,
    input wire logic                   arst_n,
    input wire logic                   rd_valid,
    input wire logic                   read_strobe_n,
    input wire logic                   write_strobe_n,
    input wire logic                   mem_ack_in,
    input wire logic [1:0]             bank_select_n,
    input wire logic [`AMP_ADDR_W-1:0] addr_pin_out,
    input wire logic [`AMP_ADDR_W-1:0] addr_pin_in,
    input wire logic [`AMP_DATA_W-1:0] data_pin_oe,
    input wire logic                   parallel_input_valid,
    input wire logic [`AMP_PDAP_W-1:0] parallel_input_port
);
    // ==========================================
    // Clocking and sequences
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    sequence s_rd_wait;
        (!read_strobe_n && !mem_ack_in) [*3];
    endsequence
    sequence s_wr_wait;
        (!write_strobe_n && !mem_ack_in) [*3];
    endsequence
    // ==========================================
    // Assertions
    a_strobe_excl: assert property (read_strobe_n || write_strobe_n)
        else $error("Both strobes low");
    a_rd_min: assert property ($fell(read_strobe_n) |-> !read_strobe_n [*2])
        else $error("Read strobe too short");
    a_rd_ack_hold: assert property (s_rd_wait |=> !read_strobe_n)
        else $error("Read ended while acknowledge low");
    a_wr_ack_hold: assert property (s_wr_wait |=> !write_strobe_n)
        else $error("Write ended while acknowledge low");
    a_wr_drive: assert property (!write_strobe_n |-> data_pin_oe == 16'hFFFF)
        else $error("Data bus not driven in write");
    a_rd_release: assert property (!read_strobe_n |-> data_pin_oe == 16'h0000)
        else $error("Data bus driven in read");
    a_sel_decode: assert property (bank_select_n != 2'h3 |-> !addr_pin_out[23]
        && bank_select_n == ~(2'h1 << addr_pin_out[22])) else $error("Bank select decode");
    a_strobe_sel: assert property ((!read_strobe_n || !write_strobe_n) && !addr_pin_out[23]
        |-> !bank_select_n[addr_pin_out[22]]) else $error("Strobe without select");
    a_rd_answer: assert property ($rose(rd_valid) |-> $past(!read_strobe_n))
        else $error("Read answer without strobe");
    a_rd_pulse: assert property (rd_valid |=> !rd_valid)
        else $error("Read answer longer than a cycle");
    a_pdap_copy: assert property (parallel_input_valid
        |-> parallel_input_port == $past(addr_pin_in[23:4])) else $error("Parallel input data");
endmodule

bind amp_top amp_top_chk u_chk (
    .core_clk, .arst_n, .rd_valid, .read_strobe_n, .write_strobe_n, .mem_ack_in,
    .bank_select_n, .addr_pin_out, .addr_pin_in, .data_pin_oe, .parallel_input_valid,
    .parallel_input_port
);

// file: testbench/amp_top_tb.sv
// Self-checking testbench for the memory port pins
`timescale 1ns/1ps
module amp_top_tb;
    logic core_clk = 1'b0, arst_n = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_cond = 1'b1;
    logic data_flag_sel = 1'b0, parallel_input_ctrl = 1'b0, timer_expired_out = 1'b0;
    logic [1:0] addr_mode_sel = 2'h0;
    logic [1:0] fpin_mode_sel [4] = '{2'h0, 2'h0, 2'h0, 2'h0};
    logic [23:0] req_addr = 24'h000000, apin_drv = 24'h000000, addr_pin_in;
    logic [15:0] req_wdata = 16'h0000, flag_out = 16'h0000, flag_dir = 16'h0000, data_pin_in;
    logic [7:0] pwm_in = 8'h00, wait_cyc = 8'h00;
    logic [3:0] pin_flag_out = 4'h0, pin_flag_dir = 4'h0, fpin_drv = 4'h0, fpin_in;
    logic mem_ack_in, req_ready, rd_valid, busy, parallel_input_valid;
    logic read_strobe_n, write_strobe_n;
    logic [15:0] rd_data, flag_in, data_pin_out, data_pin_oe;
    logic [23:0] addr_pin_out, addr_pin_oe;
    logic [19:0] parallel_input_port;
    logic [3:0] pin_flag_in, fpin_out, fpin_oe;
    logic [2:0] irq_req;
    logic [1:0] bank_select_n;
    int err_count = 0, n_tests = 0, rd_falls = 0, wr_falls = 0;

    always #4 core_clk = ~core_clk;
    always @(negedge read_strobe_n) rd_falls++;
    always @(negedge write_strobe_n) wr_falls++;
    assign addr_pin_in = (addr_pin_out & addr_pin_oe) | (apin_drv & ~addr_pin_oe);
    assign fpin_in = (fpin_out & fpin_oe) | (fpin_drv & ~fpin_oe);

    amp_top dut (
        .core_clk, .arst_n, .req_valid, .req_ready, .req_write, .req_cond, .req_addr,
        .req_wdata, .rd_valid, .rd_data, .busy, .addr_mode_sel, .data_flag_sel,
        .parallel_input_ctrl, .fpin_mode_sel, .flag_out, .flag_dir, .flag_in, .pwm_in,
        .pin_flag_out, .pin_flag_dir, .pin_flag_in, .irq_req, .timer_expired_out,
        .parallel_input_port, .parallel_input_valid, .addr_pin_in, .addr_pin_out,
        .addr_pin_oe, .data_pin_in, .data_pin_out, .data_pin_oe, .mem_ack_in,
        .bank_select_n, .read_strobe_n, .write_strobe_n, .fpin_in, .fpin_out, .fpin_oe
    );
    amp_mem_model mem (
        .core_clk, .addr(addr_pin_out), .sel_n(bank_select_n), .rd_n(read_strobe_n),
        .wr_n(write_strobe_n), .dout(data_pin_out), .doe(data_pin_oe), .wait_cyc,
        .din(data_pin_in), .ack(mem_ack_in)
    );

    // ==========================================
    // Shared tasks
    task automatic conclude();
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic await(ref logic sig, input logic lvl);
        int k;
        k = 0;
        while (sig !== lvl) begin
            @(negedge core_clk);
            k++;
            if (k > 2000) begin
                err_count++;
                $display("ERROR wait expected done seen timeout");
                conclude();
            end
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic settle();
        int q;
        q = 0;
        while (q < 4) begin
            await(busy, 1'b0);
            ticks(1);
            q = (busy === 1'b0) ? q + 1 : 0;
        end
        @(posedge core_clk);
    endtask
    task automatic push(input logic w, input logic c, input logic [23:0] a, input logic [15:0] d);
        req_valid <= 1'b1;
        req_write <= w;
        req_cond <= c;
        req_addr <= a;
        req_wdata <= d;
        ticks(1);
        await(req_ready, 1'b1);
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [23:0] a, input logic [15:0] d, input logic [1:0] s);
        push(1'b1, 1'b1, a, d);
        req_valid <= 1'b0;
        await(write_strobe_n, 1'b0);
        chk("wr_addr", a, addr_pin_out);
        chk("wr_data", d, data_pin_out);
        chk("wr_sel", {1'b1, s}, {busy, bank_select_n});
        settle();
    endtask
    task automatic rd(input logic [23:0] a, input logic [15:0] d, input logic [1:0] s);
        push(1'b0, 1'b1, a, 16'h0000);
        req_valid <= 1'b0;
        await(read_strobe_n, 1'b0);
        chk("rd_addr", a, addr_pin_out);
        chk("rd_sel", s, bank_select_n);
        await(rd_valid, 1'b1);
        chk("rd_data", d, rd_data);
        settle();
    endtask

    // ==========================================
    // Scenarios
    task automatic t_reset();
        ticks(2);
        chk("addr_oe", 24'hFFFFFF, addr_pin_oe);
        chk("sel_idle", 2'h3, bank_select_n);
        chk("strobes", 2'h3, {read_strobe_n, write_strobe_n});
        chk("fpin_oe", 4'h0, fpin_oe);
        @(posedge core_clk);
    endtask
    task automatic t_rw();
        wr(24'h000010, 16'h1234, 2'h2);
        rd(24'h000010, 16'h1234, 2'h2);
        wait_cyc <= 8'h05;
        wr(24'h400020, 16'hC3A5, 2'h1);
        rd(24'h400020, 16'hC3A5, 2'h1);
        chk("rd_count", 2, rd_falls);
        chk("wr_count", 2, wr_falls);
        wait_cyc <= 8'h00;
    endtask
    task automatic t_cond();
        push(1'b1, 1'b0, 24'h000010, 16'hDEAD);
        push(1'b0, 1'b0, 24'h000010, 16'h0000);
        req_valid <= 1'b0;
        settle();
        chk("skip_wr", 2, wr_falls);
        chk("skip_rd", 2, rd_falls);
        rd(24'h000010, 16'h1234, 2'h2);
    endtask
    task automatic t_fill();
        int acc;
        acc = 0;
        wait_cyc <= 8'h1E;
        req_valid <= 1'b1;
        req_write <= 1'b1;
        req_cond <= 1'b1;
        repeat (14) begin
            req_addr <= 24'h000030 + 24'(acc);
            req_wdata <= 16'hA000 + 16'(acc);
            ticks(1);
            if (req_ready === 1'b1) acc++;
            @(posedge core_clk);
        end
        req_valid <= 1'b0;
        chk("accepted", 9, acc);
        wait_cyc <= 8'h00;
        settle();
        for (int i = 0; i < 9; i++) begin
            rd(24'h000030 + 24'(i), 16'hA000 + 16'(i), 2'h2);
        end
    endtask
    task automatic t_pins();
        addr_mode_sel <= 2'h1;
        data_flag_sel <= 1'b1;
        flag_dir <= 16'hFFFF;
        flag_out <= 16'hA55A;
        ticks(4);
        chk("aflag_out", 16'hA5FF, {addr_pin_out[7:0], addr_pin_oe[7:0]});
        chk("dflag_out", 8'h5A, data_pin_out[7:0]);
        @(posedge core_clk);
        flag_dir <= 16'h0000;
        apin_drv <= 24'h0000C3;
        ticks(4);
        chk("flag_in", 16'hC3FF, flag_in);
        @(posedge core_clk);
        addr_mode_sel <= 2'h2;
        pwm_in <= 8'h3C;
        ticks(4);
        chk("pwm_out", 8'h3C, addr_pin_out[7:0]);
        @(posedge core_clk);
        addr_mode_sel <= 2'h0;
        data_flag_sel <= 1'b0;
        fpin_mode_sel <= '{2'h1, 2'h1, 2'h1, 2'h2};
        fpin_drv <= 4'h5;
        timer_expired_out <= 1'b1;
        ticks(4);
        chk("irq", 3'h5, irq_req);
        chk("pin_flag_in", 4'hD, pin_flag_in);
        chk("timer_pin", 2'h3, {fpin_out[3], fpin_oe[3]});
        @(posedge core_clk);
        fpin_mode_sel <= '{2'h0, 2'h0, 2'h3, 2'h3};
        pin_flag_dir <= 4'h3;
        pin_flag_out <= 4'h2;
        ticks(4);
        chk("fpin_flag", 4'hE, {fpin_oe[1:0], fpin_out[1:0]});
        @(posedge core_clk);
        push(1'b1, 1'b1, 24'h800040, 16'h0F0F);
        req_valid <= 1'b0;
        await(write_strobe_n, 1'b0);
        chk("bank2_sel", 4'h1, {bank_select_n, fpin_out[2], fpin_oe[2]} ^ 4'hC);
        settle();
        fpin_mode_sel <= '{2'h0, 2'h0, 2'h0, 2'h0};
        timer_expired_out <= 1'b0;
    endtask
    task automatic t_pdap();
        parallel_input_ctrl <= 1'b1;
        apin_drv <= 24'hABCDE0;
        ticks(4);
        chk("pdap", 21'h1ABCDE, {parallel_input_valid, parallel_input_port});
        @(posedge core_clk);
        parallel_input_ctrl <= 1'b0;
    endtask

    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_rw();
        t_cond();
        t_fill();
        t_pins();
        t_pdap();
        conclude();
    end
endmodule

// file: verilog/amp_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module amp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic core_clk,
    input  wire logic arst_n,
    amp_fifo_if.fifo  bus
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic             do_push;
    logic             do_pop;

    assign bus.push_ready = (count != DEPTH[PW:0]);
    assign bus.pop_valid  = (count != '0);
    assign bus.pop_data   = mem[rd_ptr];
    assign do_push        = bus.push_valid && bus.push_ready;
    assign do_pop         = bus.pop_valid && bus.pop_ready;

    // ========================================
    // Storage
    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr] <= bus.push_data;
        end
    end

    // ========================================
    // Pointers and fill level
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
            end
            if (do_pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
            end
            if (do_push && !do_pop) begin
                count <= (PW + 1)'(count + 1'b1);
            end else if (do_pop && !do_push) begin
                count <= (PW + 1)'(count - 1'b1);
            end
        end
    end
endmodule

// file: verilog/amp_fifo_if.sv
// Valid/ready carrier between the request FIFO and its users
`timescale 1ns/1ps
interface amp_fifo_if #(
    parameter int WIDTH = 8
);
    logic             push_valid;
    logic             push_ready;
    logic [WIDTH-1:0] push_data;
    logic             pop_valid;
    logic             pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport fifo (
        input  push_valid,
        output push_ready,
        input  push_data,
        output pop_valid,
        input  pop_ready,
        output pop_data
    );
    modport fill (
        output push_valid,
        input  push_ready,
        output push_data
    );
    modport drain (
        input  pop_valid,
        output pop_ready,
        input  pop_data
    );
endinterface

// file: verilog/amp_params.svh
// Constants for the asynchronous memory port pin block
`ifndef AMP_PARAMS_SVH
`define AMP_PARAMS_SVH
`define AMP_ADDR_W       24
`define AMP_DATA_W       16
`define AMP_REQ_W        42
`define AMP_FIFO_DEPTH   8
`define AMP_REQ_WR_BIT   41
`define AMP_REQ_COND_BIT 40
`define AMP_REQ_ADDR_HI  39
`define AMP_REQ_ADDR_LO  16
`define AMP_REQ_DATA_HI  15
`define AMP_BANK_HI      23
`define AMP_BANK_LO      22
`define AMP_PDAP_HI      23
`define AMP_PDAP_LO      4
`define AMP_PDAP_W       20
`define AMP_AFLAG_W      8
`define AMP_CNT_W        4
`define AMP_SETUP_CYC    4'h1
`define AMP_STROBE_MIN   4'h2
`define AMP_ACK_LAG      4'h3
`define AMP_HOLD_CYC     4'h1
`define AMP_CNT_ONE      4'h1
`define AMP_CNT_ZERO     4'h0
`define AMP_BANK0        2'h0
`define AMP_BANK1        2'h1
`define AMP_BANK2        2'h2
`define AMP_BANK3        2'h3
`endif

// file: verilog/amp_pkg.sv
// Types for the asynchronous memory port pin block
package amp_pkg;
    typedef enum logic [1:0] {
        AMP_ST_IDLE,
        AMP_ST_SETUP,
        AMP_ST_STROBE,
        AMP_ST_HOLD
    } amp_state_t;

    typedef enum logic [1:0] {
        AMP_ADDR_MEM,
        AMP_ADDR_FLAG,
        AMP_ADDR_PWM,
        AMP_ADDR_RSVD
    } amp_addr_mode_t;

    typedef enum logic [1:0] {
        AMP_FP_FLAG,
        AMP_FP_IRQ,
        AMP_FP_ALT,
        AMP_FP_SEL
    } amp_fpin_mode_t;
endpackage

// file: verilog/amp_top.sv
// Asynchronous external memory port: access engine and pin multiplexing
// Contract
// - Access address driven on 24-bit address bus
// - Reset: address pins memory mode, flags input
// - Address pins reassignable to flags 15-8, PWM
// - Parallel input samples address pins 23-4
// - Data pins: memory data or flags 7-0
// - Low acknowledge holds off access completion
// - Bank selects driven low per bank
// - Bank selects decoded, switch with address
// - Selects idle inactive; skipped if condition false
// - Read strobe asserted for every read word
// - Write strobe asserted for every written word
// - Flag pins 0,1 inputs or interrupt requests
// - Flag pin 2: input, IRQ2, bank 2 select
// - Flag pin 3: input, timer out, bank 3
`timescale 1ns/1ps
`include "amp_params.svh"
module amp_top (
    input  wire logic                     core_clk,
    input  wire logic                     arst_n,
    input  wire logic                     req_valid,
    output wire logic                     req_ready,
    input  wire logic                     req_write,
    input  wire logic                     req_cond,
    input  wire logic [`AMP_ADDR_W-1:0]   req_addr,
    input  wire logic [`AMP_DATA_W-1:0]   req_wdata,
    output logic                          rd_valid,
    output logic      [`AMP_DATA_W-1:0]   rd_data,
    output logic                          busy,
    input  wire logic [1:0]               addr_mode_sel,
    input  wire logic                     data_flag_sel,
    input  wire logic                     parallel_input_ctrl,
    input  wire logic [1:0]               fpin_mode_sel [4],
    input  wire logic [`AMP_DATA_W-1:0]   flag_out,
    input  wire logic [`AMP_DATA_W-1:0]   flag_dir,
    output logic      [`AMP_DATA_W-1:0]   flag_in,
    input  wire logic [`AMP_AFLAG_W-1:0]  pwm_in,
    input  wire logic [3:0]               pin_flag_out,
    input  wire logic [3:0]               pin_flag_dir,
    output logic      [3:0]               pin_flag_in,
    output logic      [2:0]               irq_req,
    input  wire logic                     timer_expired_out,
    output logic      [`AMP_PDAP_W-1:0]   parallel_input_port,
    output logic                          parallel_input_valid,
    input  wire logic [`AMP_ADDR_W-1:0]   addr_pin_in,
    output logic      [`AMP_ADDR_W-1:0]   addr_pin_out,
    output logic      [`AMP_ADDR_W-1:0]   addr_pin_oe,
    input  wire logic [`AMP_DATA_W-1:0]   data_pin_in,
    output logic      [`AMP_DATA_W-1:0]   data_pin_out,
    output logic      [`AMP_DATA_W-1:0]   data_pin_oe,
    input  wire logic                     mem_ack_in,
    output logic      [1:0]               bank_select_n,
    output logic                          read_strobe_n,
    output logic                          write_strobe_n,
    input  wire logic [3:0]               fpin_in,
    output logic      [3:0]               fpin_out,
    output logic      [3:0]               fpin_oe
);
    amp_fifo_if #(.WIDTH(`AMP_REQ_W)) req_bus ();

    amp_pkg::amp_state_t     state;
    amp_pkg::amp_addr_mode_t addr_mode;
    amp_pkg::amp_fpin_mode_t fpin_mode [4];
    logic                    data_flag;
    logic                    pdap_en;
    logic [`AMP_CNT_W-1:0]   cnt;
    logic                    cur_write;
    logic [`AMP_ADDR_W-1:0]  cur_addr;
    logic [`AMP_DATA_W-1:0]  cur_wdata;
    logic                    ack_meta;
    logic                    ack_sync;
    logic [1:0]              cur_bank;
    logic                    in_access;
    logic [`AMP_ADDR_W-1:0]  next_addr_pin_out;
    logic [`AMP_ADDR_W-1:0]  next_addr_pin_oe;
    logic [`AMP_DATA_W-1:0]  next_data_pin_out;
    logic [`AMP_DATA_W-1:0]  next_data_pin_oe;
    logic [3:0]              next_fpin_out;
    logic [3:0]              next_fpin_oe;

    // ========================================
    // Request FIFO
    assign req_bus.push_valid = req_valid;
    assign req_bus.push_data  = {req_write, req_cond, req_addr, req_wdata};
    assign req_ready          = req_bus.push_ready;
    assign req_bus.pop_ready  = (state == amp_pkg::AMP_ST_IDLE);

    amp_fifo #(
        .WIDTH (`AMP_REQ_W),
        .DEPTH (`AMP_FIFO_DEPTH)
    ) u_req_fifo (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .bus      (req_bus)
    );

    // ========================================
    // Pin configuration, memory mode after reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_mode <= amp_pkg::AMP_ADDR_MEM;
            data_flag <= 1'b0;
            pdap_en   <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                fpin_mode[i] <= amp_pkg::AMP_FP_FLAG;
            end
        end else begin
            addr_mode <= amp_pkg::amp_addr_mode_t'(addr_mode_sel);
            data_flag <= data_flag_sel;
            pdap_en   <= parallel_input_ctrl;
            for (int i = 0; i < 4; i++) begin
                fpin_mode[i] <= amp_pkg::amp_fpin_mode_t'(fpin_mode_sel[i]);
            end
        end
    end

    // ========================================
    // Acknowledge synchroniser
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_meta <= 1'b1;
            ack_sync <= 1'b1;
        end else begin
            ack_meta <= mem_ack_in;
            ack_sync <= ack_meta;
        end
    end

    // ========================================
    // Access sequencer
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state     <= amp_pkg::AMP_ST_IDLE;
            cnt       <= `AMP_CNT_ZERO;
            cur_write <= 1'b0;
            cur_addr  <= '0;
            cur_wdata <= '0;
        end else begin
            unique case (state)
                amp_pkg::AMP_ST_IDLE: begin
                    cnt <= `AMP_CNT_ZERO;
                    if (req_bus.pop_valid && req_bus.pop_data[`AMP_REQ_COND_BIT]) begin
                        cur_write <= req_bus.pop_data[`AMP_REQ_WR_BIT];
                        cur_addr  <= req_bus.pop_data[`AMP_REQ_ADDR_HI:`AMP_REQ_ADDR_LO];
                        cur_wdata <= req_bus.pop_data[`AMP_REQ_DATA_HI:0];
                        state     <= amp_pkg::AMP_ST_SETUP;
                    end
                end
                amp_pkg::AMP_ST_SETUP: begin
                    if (cnt == `AMP_SETUP_CYC - `AMP_CNT_ONE) begin
                        cnt   <= `AMP_CNT_ZERO;
                        state <= amp_pkg::AMP_ST_STROBE;
                    end else begin
                        cnt <= cnt + `AMP_CNT_ONE;
                    end
                end
                amp_pkg::AMP_ST_STROBE: begin
                    if (cnt >= `AMP_ACK_LAG) begin
                        if (ack_sync) begin
                            cnt   <= `AMP_CNT_ZERO;
                            state <= amp_pkg::AMP_ST_HOLD;
                        end
                    end else begin
                        cnt <= cnt + `AMP_CNT_ONE;
                    end
                end
                amp_pkg::AMP_ST_HOLD: begin
                    if (cnt == `AMP_HOLD_CYC - `AMP_CNT_ONE) begin
                        cnt   <= `AMP_CNT_ZERO;
                        state <= amp_pkg::AMP_ST_IDLE;
                    end else begin
                        cnt <= cnt + `AMP_CNT_ONE;
                    end
                end
            endcase
        end
    end

    assign in_access = (state != amp_pkg::AMP_ST_IDLE);
    assign cur_bank  = cur_addr[`AMP_BANK_HI:`AMP_BANK_LO];

    // ========================================
    // Read data return
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_valid <= 1'b0;
            rd_data  <= '0;
        end else begin
            rd_valid <= 1'b0;
            if (state == amp_pkg::AMP_ST_STROBE && !cur_write && ack_sync &&
                cnt >= `AMP_ACK_LAG) begin
                rd_valid <= 1'b1;
                rd_data  <= data_pin_in;
            end
        end
    end

    // ========================================
    // Strobes and bank selects
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            bank_select_n  <= 2'h3;
            busy           <= 1'b0;
        end else begin
            busy           <= in_access;
            read_strobe_n  <= !(state == amp_pkg::AMP_ST_STROBE && !cur_write);
            write_strobe_n <= !(state == amp_pkg::AMP_ST_STROBE && cur_write);
            bank_select_n[0] <= !(in_access && cur_bank == `AMP_BANK0);
            bank_select_n[1] <= !(in_access && cur_bank == `AMP_BANK1);
        end
    end

    // ========================================
    // Address and data pin multiplexing
    always_comb begin
        next_addr_pin_out = cur_addr;
        next_addr_pin_oe  = '1;
        unique case (addr_mode)
            amp_pkg::AMP_ADDR_MEM: begin
                next_addr_pin_out = cur_addr;
            end
            amp_pkg::AMP_ADDR_FLAG: begin
                next_addr_pin_out[`AMP_AFLAG_W-1:0] = flag_out[`AMP_DATA_W-1:`AMP_AFLAG_W];
                next_addr_pin_oe[`AMP_AFLAG_W-1:0]  = flag_dir[`AMP_DATA_W-1:`AMP_AFLAG_W];
            end
            amp_pkg::AMP_ADDR_PWM: begin
                next_addr_pin_out[`AMP_AFLAG_W-1:0] = pwm_in;
            end
            default: begin
                next_addr_pin_out = cur_addr;
            end
        endcase
        if (pdap_en) begin
            next_addr_pin_oe[`AMP_PDAP_HI:`AMP_PDAP_LO] = '0;
        end
        next_data_pin_out = cur_wdata;
        next_data_pin_oe  = {`AMP_DATA_W{in_access && cur_write}};
        if (data_flag) begin
            next_data_pin_out[`AMP_AFLAG_W-1:0] = flag_out[`AMP_AFLAG_W-1:0];
            next_data_pin_oe[`AMP_AFLAG_W-1:0]  = flag_dir[`AMP_AFLAG_W-1:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_pin_out <= '0;
            addr_pin_oe  <= '0;
            data_pin_out <= '0;
            data_pin_oe  <= '0;
        end else begin
            addr_pin_out <= next_addr_pin_out;
            addr_pin_oe  <= next_addr_pin_oe;
            data_pin_out <= next_data_pin_out;
            data_pin_oe  <= next_data_pin_oe;
        end
    end

    // ========================================
    // Flag inputs and parallel input sampling
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_in              <= '0;
            parallel_input_port  <= '0;
            parallel_input_valid <= 1'b0;
        end else begin
            flag_in[`AMP_DATA_W-1:`AMP_AFLAG_W] <= (addr_mode == amp_pkg::AMP_ADDR_FLAG) ?
                addr_pin_in[`AMP_AFLAG_W-1:0] : '0;
            flag_in[`AMP_AFLAG_W-1:0] <= data_flag ? data_pin_in[`AMP_AFLAG_W-1:0] : '0;
            parallel_input_valid <= pdap_en;
            if (pdap_en) begin
                parallel_input_port <= addr_pin_in[`AMP_PDAP_HI:`AMP_PDAP_LO];
            end
        end
    end

    // ========================================
    // Dedicated flag pins 0 to 3
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            next_fpin_out[i] = pin_flag_out[i];
            next_fpin_oe[i]  = (fpin_mode[i] == amp_pkg::AMP_FP_FLAG) && pin_flag_dir[i];
        end
        if (fpin_mode[2] == amp_pkg::AMP_FP_SEL) begin
            next_fpin_out[2] = !(in_access && cur_bank == `AMP_BANK2);
            next_fpin_oe[2]  = 1'b1;
        end
        if (fpin_mode[3] == amp_pkg::AMP_FP_ALT) begin
            next_fpin_out[3] = timer_expired_out;
            next_fpin_oe[3]  = 1'b1;
        end else if (fpin_mode[3] == amp_pkg::AMP_FP_SEL) begin
            next_fpin_out[3] = !(in_access && cur_bank == `AMP_BANK3);
            next_fpin_oe[3]  = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            fpin_out    <= '0;
            fpin_oe     <= '0;
            pin_flag_in <= '0;
            irq_req     <= '0;
        end else begin
            fpin_out    <= next_fpin_out;
            fpin_oe     <= next_fpin_oe;
            pin_flag_in <= fpin_in;
            for (int i = 0; i < 3; i++) begin
                irq_req[i] <= (fpin_mode[i] == amp_pkg::AMP_FP_IRQ) && fpin_in[i];
            end
        end
    end
endmodule
